//--- rtl/ssc_pkg.sv
package ssc_pkg;

   localparam int NREG = 37;

   localparam int I_PAD_OUTPUT_ENABLE_0 = 0;
   localparam int I_PAD_OUTPUT_ENABLE_2 = 1;
   localparam int I_SLAVE_ID = 2;
   localparam int I_CLK_RST_SRC = 3;
   localparam int I_SECOND_ID = 4;
   localparam int I_OUT_SRC_SEL = 5;
   localparam int I_IDENT_HI = 6;
   localparam int I_IDENT_MID = 7;
   localparam int I_IDENT_LO = 8;
   localparam int I_PAD_OUT = 9;
   localparam int I_PAD_SEL = 10;
   localparam int I_ALT_ID = 12;
   localparam int I_PUMP_DIV = 13;
   localparam int I_LANE_CTRL = 14;
   localparam int I_LANE_DIS = 15;
   localparam int I_GATE0 = 16;
   localparam int I_MISC = 22;
   localparam int I_SER_CTRL2 = 23;
   localparam int I_ANA_RST = 25;
   localparam int I_REVISION = 26;
   localparam int I_PCLK_POL = 27;
   localparam int I_BIT_WIDTH = 28;
   localparam int I_ID_PIN = 34;
   localparam int I_ID_RESP = 36;
   localparam int NGATE = 5;

   localparam logic [15:0] REG_ADDR [NREG] = '{
      16'h3000, 16'h3002, 16'h3004, 16'h3005, 16'h3006, 16'h3007, 16'h300a, 16'h300b,
      16'h300c, 16'h300d, 16'h3010, 16'h3011, 16'h3012, 16'h3015, 16'h3018, 16'h3019,
      16'h301a, 16'h301b, 16'h301c, 16'h301d, 16'h301e, 16'h3020, 16'h3021, 16'h3022,
      16'h3023, 16'h3024, 16'h302a, 16'h3030, 16'h3031, 16'h3032, 16'h3033, 16'h3034,
      16'h3035, 16'h3036, 16'h3037, 16'h303e, 16'h303f};

   // values after reset, before the functional mask is applied
   localparam logic [7:0] REG_RST [NREG] = '{
      8'h00, 8'h20, 8'h6c, 8'hf0, 8'h42, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h32, 8'h00,
      8'hf0, 8'hd0, 8'hf0, 8'hd0, 8'hf0, 8'h93, 8'h23, 8'h01,
      8'h00, 8'h10, 8'h00, 8'h00, 8'h0a, 8'h80, 8'h24, 8'h00,
      8'h00, 8'h2b, 8'h00, 8'h03, 8'h00};

   // bits that hold a function; all others are stored as zero
   localparam logic [7:0] REG_MASK [NREG] = '{
      8'h20, 8'h0d, 8'hff, 8'h33, 8'hff, 8'hef, 8'h00, 8'h00,
      8'h00, 8'h8f, 8'hdf, 8'h00, 8'hff, 8'h77, 8'hff, 8'hff,
      8'hff, 8'hff, 8'h77, 8'hff, 8'hfc, 8'hf9, 8'h7f, 8'h0f,
      8'h00, 8'h04, 8'h00, 8'h10, 8'h1f, 8'h58, 8'hff, 8'hff,
      8'h0f, 8'h3f, 8'h01, 8'h07, 8'h03};

   // field positions
   localparam int B_FS_SEL_LO = 0;
   localparam int B_LANE_MODE_LO = 5;
   localparam int B_IF_SEL = 4;
   localparam int B_PHY_RST_OPT = 1;
   localparam int B_LANE_DIS_OPT = 0;
   localparam int B_PD_ON_RST = 0;
   localparam int B_FAST_SBY = 4;
   localparam int B_REMOTE_EN = 3;
   localparam int B_REMOTE_SEL = 2;
   localparam int B_PUMP_N_LO = 4;
   localparam int B_PUMP_P_LO = 0;
   localparam int B_ANA_RST = 2;
   localparam int B_PCLK_INV = 4;
   localparam int B_PGM_ID_EN = 0;
   localparam int B_ID2_NACK = 1;
   localparam int B_ID_PIN = 0;

   localparam logic [2:0] PUMP_MAX_CODE = 3'h4;
   localparam logic [4:0] WIDTH_8 = 5'h08;
   localparam logic [4:0] WIDTH_10 = 5'h0a;
   localparam logic [4:0] WIDTH_12 = 5'h0c;

   typedef enum logic [2:0] {
      SBY_RUN = 3'b001,
      SBY_WAIT = 3'b010,
      SBY_HOLD = 3'b100
   } ssc_sby_t;

   typedef struct packed {
      logic serial;
      logic diff;
      logic formatter;
      logic timing;
   } ssc_fsync_src_t;

   typedef struct packed {
      logic [7:0] oen;
      logic [7:0] value;
      logic [7:0] sel;
   } ssc_pad_t;

   typedef struct packed {
      logic use_serial;
      logic [3:0] lanes;
      logic phy_reset;
      logic powerdown;
      logic [7:0] lane_disable;
   } ssc_serial_t;

   typedef struct packed {
      logic [NREG-1:0][7:0] regs;
      logic [7:0] rdata;
      logic [4:0] pump_cnt;
      logic pump_n_tick;
      logic pump_p_tick;
      ssc_sby_t sby;
      logic fsync;
      logic remote_reg_rst;
      logic remote_dig_rst;
      logic remote_suspend;
      ssc_serial_t ser;
      logic [7:0] slave_id;
   } ssc_state_t;

endpackage

//--- rtl/ssc_regs.sv
`timescale 1ns/1ps
module ssc_regs
   import ssc_pkg::*;
#(
   parameter logic [7:0] IDENT_HIGH = 8'h5a, // arbitrary value
   parameter logic [7:0] IDENT_MID = 8'h3c,  // arbitrary value
   parameter logic [7:0] IDENT_LOW = 8'h81,  // arbitrary value
   parameter logic [7:0] REVISION = 8'h11    // arbitrary value
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   // register port
   input wire logic [15:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   // sensor events
   input wire logic SYNC_RESET_IN,
   input wire ssc_fsync_src_t FSYNC_SRC_IN,
   input wire logic STANDBY_REQ_IN,
   input wire logic LINE_BLANK_IN,
   input wire logic FRAME_BLANK_IN,
   input wire logic REMOTE_RESET_CMD_IN,
   input wire logic REMOTE_SUSPEND_CMD_IN,
   input wire logic SID_PIN_IN,
   // frame sync and standby
   output logic FSYNC_OUT,
   output logic STANDBY_OUT,
   // remote command results
   output logic REMOTE_REG_RESET_OUT,
   output logic REMOTE_DIGITAL_RESET_OUT,
   output logic REMOTE_SUSPEND_OUT,
   // serial output control
   output ssc_serial_t SERIAL_OUT,
   // pump clock enables
   output logic PUMP_N_TICK_OUT,
   output logic PUMP_P_TICK_OUT,
   // pads
   output ssc_pad_t PAD_OUT,
   // clock gates and resets
   output logic [NGATE-1:0][3:0] CLK_GATE_OUT,
   output logic [NGATE-1:0][3:0] SUB_RESET_OUT,
   output logic ANALOG_RESET_OUT,
   // pixel output format
   output logic PCLK_INVERT_OUT,
   output logic [4:0] PIXEL_WIDTH_OUT,
   output logic PIXEL_WIDTH_VALID_OUT,
   // control bus identity
   output logic [7:0] SLAVE_ID_OUT,
   output logic [7:0] SECOND_ID_OUT,
   output logic SECOND_ID_NACK_OUT
);

   ssc_state_t q, d;

   // one enable pulse every 2^(code+1) cycles; unlisted codes stop the pump
   function automatic logic pump_tick(input logic [2:0] code, input logic [4:0] cnt);
      logic [4:0] m;
      m = 5'h00;
      for (int i = 0; i < 5; i++) begin
         if (i <= int'(code)) begin
            m[i] = 1'b1;
         end
      end
      return (code <= PUMP_MAX_CODE) && ((cnt & m) == m);
   endfunction

   function automatic logic [7:0] reg_reset(input int i);
      return REG_RST[i] & REG_MASK[i];
   endfunction

   logic [7:0] r_lane, r_misc, r_ser2, r_pump, r_sel, r_id_resp, r_width;

   always_comb begin
      r_lane = q.regs[I_LANE_CTRL];
      r_misc = q.regs[I_MISC];
      r_ser2 = q.regs[I_SER_CTRL2];
      r_pump = q.regs[I_PUMP_DIV];
      r_sel = q.regs[I_OUT_SRC_SEL];
      r_id_resp = q.regs[I_ID_RESP];
      r_width = q.regs[I_BIT_WIDTH];
   end

   always_comb begin
      logic hit;
      logic [7:0] rval;
      logic remote_ok;
      hit = 1'b0;
      rval = 8'h00;
      remote_ok = 1'b0;
      d = q;

      // register writes keep only the functional bits
      for (int i = 0; i < NREG; i++) begin
         if (WR_IN && ADDR_IN == REG_ADDR[i]) begin
            d.regs[i] = WDATA_IN & REG_MASK[i];
         end
      end
      // identification bytes are never stored
      d.regs[I_IDENT_HI] = 8'h00;
      d.regs[I_IDENT_MID] = 8'h00;
      d.regs[I_IDENT_LO] = 8'h00;
      d.regs[I_REVISION] = 8'h00;

      // read data stands for exactly the cycle after the strobe
      for (int i = 0; i < NREG; i++) begin
         if (ADDR_IN == REG_ADDR[i]) begin
            hit = 1'b1;
            rval = q.regs[i];
         end
      end
      if (ADDR_IN == REG_ADDR[I_IDENT_HI]) begin
         rval = IDENT_HIGH;
      end
      if (ADDR_IN == REG_ADDR[I_IDENT_MID]) begin
         rval = IDENT_MID;
      end
      if (ADDR_IN == REG_ADDR[I_IDENT_LO]) begin
         rval = IDENT_LOW;
      end
      if (ADDR_IN == REG_ADDR[I_REVISION]) begin
         rval = REVISION;
      end
      d.rdata = (RD_IN && hit) ? rval : 8'h00;

      // pump clock enables from one shared free-running counter
      d.pump_cnt = q.pump_cnt + 5'h01;
      d.pump_n_tick = pump_tick(r_pump[B_PUMP_N_LO +: 3], q.pump_cnt);
      d.pump_p_tick = pump_tick(r_pump[B_PUMP_P_LO +: 3], q.pump_cnt);

      // frame sync source
      case (r_sel[B_FS_SEL_LO +: 2])
         2'h0: d.fsync = FSYNC_SRC_IN.serial;
         2'h1: d.fsync = FSYNC_SRC_IN.diff;
         2'h2: d.fsync = FSYNC_SRC_IN.formatter;
         default: d.fsync = FSYNC_SRC_IN.timing;
      endcase

      // serial output controls
      d.ser.use_serial = r_lane[B_IF_SEL];
      d.ser.lanes = {1'b0, r_lane[B_LANE_MODE_LO +: 3]} + 4'h1;
      d.ser.phy_reset = r_lane[B_PHY_RST_OPT] & SYNC_RESET_IN;
      d.ser.powerdown = r_ser2[B_PD_ON_RST] & SYNC_RESET_IN;
      // manual mask works alone; automatic disable adds all lanes
      d.ser.lane_disable = q.regs[I_LANE_DIS] |
         {8{r_lane[B_LANE_DIS_OPT] & d.ser.powerdown}};

      // software standby entry waits for a blanking interval
      case (q.sby)
         SBY_RUN: begin
            if (STANDBY_REQ_IN) begin
               d.sby = SBY_WAIT;
            end
         end
         SBY_WAIT: begin
            if (!STANDBY_REQ_IN) begin
               d.sby = SBY_RUN;
            end else if (FRAME_BLANK_IN || (r_misc[B_FAST_SBY] && LINE_BLANK_IN)) begin
               d.sby = SBY_HOLD;
            end
         end
         SBY_HOLD: begin
            if (!STANDBY_REQ_IN) begin
               d.sby = SBY_RUN;
            end
         end
         default: d.sby = SBY_RUN;
      endcase

      // remote commands are registered for one cycle, gated by the remote enable bit
      remote_ok = r_misc[B_REMOTE_EN];
      d.remote_reg_rst = remote_ok && REMOTE_RESET_CMD_IN && !r_misc[B_REMOTE_SEL];
      d.remote_dig_rst = remote_ok && REMOTE_RESET_CMD_IN && r_misc[B_REMOTE_SEL];
      d.remote_suspend = remote_ok && REMOTE_SUSPEND_CMD_IN;

      // active slave address: programmed id, else alternate id when the pin or the I_ID_PIN bit is set, else the default
      if (r_id_resp[B_PGM_ID_EN]) begin
         d.slave_id = q.regs[I_SLAVE_ID];
      end else if (SID_PIN_IN || q.regs[I_ID_PIN][B_ID_PIN]) begin
         d.slave_id = q.regs[I_ALT_ID];
      end else begin
         d.slave_id = REG_RST[I_SLAVE_ID];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         for (int i = 0; i < NREG; i++) begin
            q.regs[i] <= reg_reset(i);
         end
         q.rdata <= 8'h00;
         q.pump_cnt <= 5'h00;
         q.pump_n_tick <= 1'b0;
         q.pump_p_tick <= 1'b0;
         q.sby <= SBY_RUN;
         q.fsync <= 1'b0;
         q.remote_reg_rst <= 1'b0;
         q.remote_dig_rst <= 1'b0;
         q.remote_suspend <= 1'b0;
         q.ser <= '0;
         q.slave_id <= REG_RST[I_SLAVE_ID];
      end else begin
         q <= d;
      end
   end

   // pixel width decode; unused codes fall back to no valid width
   always_comb begin
      case (r_width[4:0])
         WIDTH_8, WIDTH_10, WIDTH_12: begin
            PIXEL_WIDTH_OUT = r_width[4:0];
            PIXEL_WIDTH_VALID_OUT = 1'b1;
         end
         default: begin
            PIXEL_WIDTH_OUT = r_width[4:0];
            PIXEL_WIDTH_VALID_OUT = 1'b0;
         end
      endcase
   end

   // clock gates in the high nibble, resets in the low nibble
   always_comb begin
      for (int g = 0; g < NGATE; g++) begin
         CLK_GATE_OUT[g] = q.regs[I_GATE0 + g][7:4];
         SUB_RESET_OUT[g] = q.regs[I_GATE0 + g][3:0];
      end
   end

   always_comb begin
      PAD_OUT.oen = q.regs[I_PAD_OUTPUT_ENABLE_2] | q.regs[I_PAD_OUTPUT_ENABLE_0];
      PAD_OUT.value = q.regs[I_PAD_OUT];
      PAD_OUT.sel = q.regs[I_PAD_SEL];
   end

   assign RDATA_OUT = q.rdata;
   assign FSYNC_OUT = q.fsync;
   assign STANDBY_OUT = (q.sby == SBY_HOLD);
   assign REMOTE_REG_RESET_OUT = q.remote_reg_rst;
   assign REMOTE_DIGITAL_RESET_OUT = q.remote_dig_rst;
   assign REMOTE_SUSPEND_OUT = q.remote_suspend;
   assign SERIAL_OUT = q.ser;
   assign PUMP_N_TICK_OUT = q.pump_n_tick;
   assign PUMP_P_TICK_OUT = q.pump_p_tick;
   assign ANALOG_RESET_OUT = q.regs[I_ANA_RST][B_ANA_RST];
   assign PCLK_INVERT_OUT = q.regs[I_PCLK_POL][B_PCLK_INV];
   assign SLAVE_ID_OUT = q.slave_id;
   assign SECOND_ID_OUT = q.regs[I_SECOND_ID];
   assign SECOND_ID_NACK_OUT = r_id_resp[B_ID2_NACK];

endmodule

//--- test/ssc_regs_props.sv
`timescale 1ns/1ps
module ssc_regs_props
   import ssc_pkg::*;
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   // watched inputs
   input wire logic [15:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic SYNC_RESET_IN,
   input wire logic REMOTE_RESET_CMD_IN,
   // watched outputs
   input wire logic REMOTE_REG_RESET_OUT,
   input wire logic REMOTE_DIGITAL_RESET_OUT,
   input wire ssc_serial_t SERIAL_OUT,
   input wire logic PCLK_INVERT_OUT,
   input wire logic [4:0] PIXEL_WIDTH_OUT,
   input wire logic PIXEL_WIDTH_VALID_OUT
);
   default clocking @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   chk_width_write:
      assert property (WR_IN && ADDR_IN == 16'h3031 |=> PIXEL_WIDTH_OUT == $past(WDATA_IN[4:0]))
      else $error("pixel width not taken from write");
   chk_width_valid:
      assert property (PIXEL_WIDTH_VALID_OUT == (PIXEL_WIDTH_OUT inside {5'h08, 5'h0a, 5'h0c}))
      else $error("pixel width valid flag wrong");
   chk_pclk_write:
      assert property (WR_IN && ADDR_IN == 16'h3030 |=> PCLK_INVERT_OUT == $past(WDATA_IN[4]))
      else $error("pixel clock inversion not taken from write");
   chk_pd_cause:
      assert property (SERIAL_OUT.powerdown |-> $past(SYNC_RESET_IN))
      else $error("serial power-down without sync reset");
   chk_phy_cause:
      assert property (SERIAL_OUT.phy_reset |-> $past(SYNC_RESET_IN))
      else $error("phy reset without sync reset");
   chk_lane_count:
      assert property ($past(RST_N_IN) |-> SERIAL_OUT.lanes inside {[4'h1:4'h8]})
      else $error("lane count out of range");
   chk_remote_cause:
      assert property (REMOTE_REG_RESET_OUT || REMOTE_DIGITAL_RESET_OUT |-> $past(REMOTE_RESET_CMD_IN))
      else $error("remote reset without command");
   chk_remote_scope:
      assert property (!(REMOTE_REG_RESET_OUT && REMOTE_DIGITAL_RESET_OUT))
      else $error("both remote reset scopes at once");
endmodule
bind ssc_regs ssc_regs_props ssc_regs_props_inst (
   .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
   .SYNC_RESET_IN(SYNC_RESET_IN), .REMOTE_RESET_CMD_IN(REMOTE_RESET_CMD_IN),
   .REMOTE_REG_RESET_OUT(REMOTE_REG_RESET_OUT), .REMOTE_DIGITAL_RESET_OUT(REMOTE_DIGITAL_RESET_OUT),
   .SERIAL_OUT(SERIAL_OUT), .PCLK_INVERT_OUT(PCLK_INVERT_OUT), .PIXEL_WIDTH_OUT(PIXEL_WIDTH_OUT),
   .PIXEL_WIDTH_VALID_OUT(PIXEL_WIDTH_VALID_OUT));

//--- test/ssc_regs_tb.sv
`timescale 1ns/1ps
module ssc_regs_tb;
   import ssc_pkg::*;
   localparam logic [7:0] ID_HI = 8'ha5; // arbitrary value
   localparam logic [7:0] ID_MID = 8'h96; // arbitrary value
   localparam logic [7:0] ID_LO = 8'h3e; // arbitrary value
   localparam logic [7:0] REV = 8'h71; // arbitrary value
   logic CLK_IN = 0, RST_N_IN = 0, WR_IN = 0, RD_IN = 0, SYNC_RESET_IN = 0, STANDBY_REQ_IN = 0;
   logic LINE_BLANK_IN = 0, FRAME_BLANK_IN = 0, REMOTE_RESET_CMD_IN = 0, SID_PIN_IN = 0;
   logic REMOTE_SUSPEND_CMD_IN = 0, FSYNC_OUT, STANDBY_OUT, REM_R, REM_D, REM_S, TICK_N, TICK_P;
   logic ANALOG_RESET_OUT, PCLK_INVERT_OUT, PIXEL_WIDTH_VALID_OUT, NACK, rd_p = 0;
   logic [15:0] ADDR_IN = 16'h0;
   logic [7:0] WDATA_IN = 8'h0, RDATA_OUT, SLAVE_ID_OUT, SECOND_ID_OUT, d;
   logic [4:0] PIXEL_WIDTH_OUT;
   logic [4:0] wcode [4] = '{5'h08, 5'h0a, 5'h0c, 5'h0b};
   logic [NGATE-1:0][3:0] CLK_GATE_OUT, SUB_RESET_OUT;
   ssc_fsync_src_t FSYNC_SRC_IN = '0;
   ssc_serial_t SERIAL_OUT;
   ssc_pad_t PAD_OUT;
   logic [7:0] exp_q [$];
   int bad_count = 0, checks = 0, seed = 62, n_cnt, p_cnt;
   ssc_regs #(.IDENT_HIGH(ID_HI), .IDENT_MID(ID_MID), .IDENT_LOW(ID_LO), .REVISION(REV)) ssc_regs_inst (
      .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
      .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .SYNC_RESET_IN(SYNC_RESET_IN), .FSYNC_SRC_IN(FSYNC_SRC_IN),
      .STANDBY_REQ_IN(STANDBY_REQ_IN), .LINE_BLANK_IN(LINE_BLANK_IN), .FRAME_BLANK_IN(FRAME_BLANK_IN),
      .REMOTE_RESET_CMD_IN(REMOTE_RESET_CMD_IN), .REMOTE_SUSPEND_CMD_IN(REMOTE_SUSPEND_CMD_IN),
      .SID_PIN_IN(SID_PIN_IN), .FSYNC_OUT(FSYNC_OUT), .STANDBY_OUT(STANDBY_OUT),
      .REMOTE_REG_RESET_OUT(REM_R), .REMOTE_DIGITAL_RESET_OUT(REM_D), .REMOTE_SUSPEND_OUT(REM_S),
      .SERIAL_OUT(SERIAL_OUT), .PUMP_N_TICK_OUT(TICK_N), .PUMP_P_TICK_OUT(TICK_P), .PAD_OUT(PAD_OUT),
      .CLK_GATE_OUT(CLK_GATE_OUT), .SUB_RESET_OUT(SUB_RESET_OUT), .ANALOG_RESET_OUT(ANALOG_RESET_OUT),
      .PCLK_INVERT_OUT(PCLK_INVERT_OUT), .PIXEL_WIDTH_OUT(PIXEL_WIDTH_OUT),
      .PIXEL_WIDTH_VALID_OUT(PIXEL_WIDTH_VALID_OUT), .SLAVE_ID_OUT(SLAVE_ID_OUT),
      .SECOND_ID_OUT(SECOND_ID_OUT), .SECOND_ID_NACK_OUT(NACK));
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge CLK_IN);
      ADDR_IN <= a;
      WDATA_IN <= v;
      WR_IN <= 1'b1;
      RD_IN <= 1'b0;
      // strobe is one cycle long, whatever the caller does next
      @(posedge CLK_IN);
      WR_IN <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge CLK_IN);
      ADDR_IN <= a;
      RD_IN <= 1'b1;
      WR_IN <= 1'b0;
      exp_q.push_back(e);
      @(posedge CLK_IN);
      RD_IN <= 1'b0;
   endtask
   // strobes drop, then look at the outputs n falling edges later, away from any rising edge
   task automatic idle(input int n);
      @(posedge CLK_IN);
      WR_IN <= 1'b0;
      RD_IN <= 1'b0;
      repeat (n) @(negedge CLK_IN);
   endtask
   task automatic remote(input logic r, input logic s, input logic [2:0] e);
      @(posedge CLK_IN);
      REMOTE_RESET_CMD_IN <= r;
      REMOTE_SUSPEND_CMD_IN <= s;
      WR_IN <= 1'b0;
      @(posedge CLK_IN);
      REMOTE_RESET_CMD_IN <= 1'b0;
      REMOTE_SUSPEND_CMD_IN <= 1'b0;
      @(negedge CLK_IN);
      chk({REM_R, REM_D, REM_S}, e);
   endtask
   function automatic logic [7:0] rval(input int i, input logic [7:0] v);
      case (i)
         I_IDENT_HI: return ID_HI;
         I_IDENT_MID: return ID_MID;
         I_IDENT_LO: return ID_LO;
         I_REVISION: return REV;
         default: return v & REG_MASK[i];
      endcase
   endfunction
   // read data are looked at only in the cycle after the read strobe
   always @(posedge CLK_IN) begin
      if (rd_p) begin
         if (exp_q.size() == 0) chk(24'h1, 24'h0);
         else chk(RDATA_OUT, exp_q.pop_front());
      end
      rd_p <= RD_IN;
   end
   initial forever #4 CLK_IN = ~CLK_IN;
   initial begin
      #400000;
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge CLK_IN);
      RST_N_IN <= 1'b1;
      for (int i = 0; i < NREG; i++) rd(REG_ADDR[i], rval(i, REG_RST[i]));
      idle(1);
      chk({SLAVE_ID_OUT, 10'h0, PCLK_INVERT_OUT, PIXEL_WIDTH_OUT}, 24'h6c000a);
      for (int g = 0; g < NGATE; g++) begin
         chk({16'h0, CLK_GATE_OUT[g], SUB_RESET_OUT[g]},
            {16'h0, REG_RST[I_GATE0 + g] & REG_MASK[I_GATE0 + g]});
      end
      for (int i = 0; i < NREG; i++) begin
         d = 8'($random(seed));
         wr(REG_ADDR[i], d);
         rd(REG_ADDR[i], rval(i, d));
      end
      wr(16'h3001, 8'hff);
      rd(16'h3001, 8'h00);
      idle(2);
      @(posedge CLK_IN) RST_N_IN <= 1'b0;
      repeat (3) @(posedge CLK_IN);
      RST_N_IN <= 1'b1;
      foreach (wcode[k]) begin
         wr(16'h3031, {3'h7, wcode[k]});
         idle(1);
         chk({PIXEL_WIDTH_VALID_OUT, PIXEL_WIDTH_OUT}, {wcode[k] != 5'h0b, wcode[k]});
      end
      for (int s = 0; s < 4; s++) begin
         wr(16'h3007, 8'(s));
         @(posedge CLK_IN) FSYNC_SRC_IN <= 4'b1000 >> s;
         idle(1);
         chk(FSYNC_OUT, 1'b1);
         @(posedge CLK_IN) FSYNC_SRC_IN <= ~(4'b1000 >> s);
         idle(1);
         chk(FSYNC_OUT, 1'b0);
      end
      for (int c = 0; c < 6; c++) begin
         wr(16'h3015, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
         idle(2);
         n_cnt = 0;
         p_cnt = 0;
         repeat (64) begin
            @(negedge CLK_IN);
            n_cnt += int'(TICK_N === 1'b1);
            p_cnt += int'(TICK_P === 1'b1);
         end
         chk(24'(n_cnt), (c > 4) ? 24'h0 : 24'(64 >> (c + 1)));
         chk(24'(p_cnt), (7 - c > 4) ? 24'h0 : 24'(64 >> (8 - c)));
      end
      wr(16'h3018, 8'he3);
      wr(16'h3019, 8'h5a);
      @(posedge CLK_IN) SYNC_RESET_IN <= 1'b1;
      idle(2);
      chk(SERIAL_OUT, {1'b0, 4'h8, 1'b1, 1'b1, 8'hff});
      wr(16'h3022, 8'h00);
      idle(2);
      chk(SERIAL_OUT, {1'b0, 4'h8, 1'b1, 1'b0, 8'h5a});
      wr(16'h3018, 8'h10);
      @(posedge CLK_IN) SYNC_RESET_IN <= 1'b0;
      idle(2);
      chk(SERIAL_OUT, {1'b1, 4'h1, 1'b0, 1'b0, 8'h5a});
      remote(1'b1, 1'b1, 3'b000);
      wr(16'h3021, 8'h08);
      remote(1'b1, 1'b0, 3'b100);
      wr(16'h3021, 8'h0c);
      remote(1'b1, 1'b1, 3'b011);
      wr(16'h3021, 8'h00);
      @(posedge CLK_IN) STANDBY_REQ_IN <= 1'b1;
      LINE_BLANK_IN <= 1'b1;
      idle(4);
      chk(STANDBY_OUT, 1'b0);
      @(posedge CLK_IN) FRAME_BLANK_IN <= 1'b1;
      idle(1);
      chk(STANDBY_OUT, 1'b1);
      @(posedge CLK_IN) STANDBY_REQ_IN <= 1'b0;
      FRAME_BLANK_IN <= 1'b0;
      idle(1);
      chk(STANDBY_OUT, 1'b0);
      wr(16'h3021, 8'h10);
      @(posedge CLK_IN) STANDBY_REQ_IN <= 1'b1;
      idle(2);
      chk(STANDBY_OUT, 1'b1);
      wr(16'h3002, 8'hff);
      wr(16'h300d, 8'hff);
      wr(16'h3010, 8'hff);
      wr(16'h301a, 8'h5a);
      wr(16'h3024, 8'hff);
      wr(16'h3030, 8'hff);
      @(posedge CLK_IN) SID_PIN_IN <= 1'b1;
      idle(2);
      chk(PAD_OUT, 24'h0d8fdf);
      chk({CLK_GATE_OUT[0], SUB_RESET_OUT[0], ANALOG_RESET_OUT, PCLK_INVERT_OUT}, 10'h16b);
      chk({SLAVE_ID_OUT, SECOND_ID_OUT, 7'h0, NACK}, 24'h204200);
      wr(16'h3004, 8'h77);
      wr(16'h303f, 8'h03);
      idle(2);
      chk({SLAVE_ID_OUT, SECOND_ID_OUT, 7'h0, NACK}, 24'h774201);
      chk(24'(exp_q.size()), 24'h0);
      print_verdict();
   end
endmodule
